//--- logic/pio_port_ctrl.sv
/*
 Port latches, output modes, pull-ups, pin reads and memory interface takeover.
 Assumes an SFR bus on clock: byte and bit writes, page selector from the core,
 pins brought to the clock only through this block's own two-stage synchroniser.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.svh"

// Contract
// - Routing register three: bit7 CAN transmit push-pull, low nibble route enables.
// - Port reads return synchronised live pin levels regardless of routing.
// - Read-modify-write read phase returns the stored latch instead of pins.
// - Port four has only bits 5 to 7; others read zero.
// - High port data and mode registers answer only on page F.
// - Push-pull: latch zero drives low, latch one drives high.
// - Open-drain: latch zero drives low, latch one floats.
// - Output mode bit one selects push-pull, zero open-drain.
// - Reset returns all output modes to open-drain.
// - Pull-ups on by default; global disable bit turns all off.
// - Pull-up is off on any pin driving low.
// - Memory interface sets high-port pin levels during off-chip moves.
// - Moves keep modes; external reads disable data bus drivers outside the multiplexed address phase.
// - Analog port-one pins read zero digitally, keep latch-driven output.
// - Unbonded port registers stay readable, writable, inputs active.
// - Interface drives port four bits 7,6,5 as write, read, ALE.
// - Non-multiplexed: port five carries address bits 15 to 8.
// - Port six: high address multiplexed, low address non-multiplexed.
// - Port seven: address/data multiplexed, data only non-multiplexed.
module pio_port_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWdata,
  input wire logic sfrWrite,
  input wire logic sfrBitWrite,
  input wire pio_pkg::pio_index_type sfrBitSel,
  input wire logic sfrBitVal,
  input wire logic sfrRead,
  input wire logic sfrRmwRead,
  input wire pio_pkg::pio_byte_type registerPageSelect,
  output pio_pkg::pio_byte_type sfrRdata,
  input wire logic [63:0] pinIn,
  output logic [63:0] pinOut,
  output logic [63:0] pinOe,
  output logic [63:0] pullupEn,
  input wire logic emifActive,
  input wire pio_pkg::pio_external_memory_interface_mode_type emifMode,
  input wire logic emifExtRead,
  input wire logic [15:0] emifAddr,
  input wire logic [7:0] emifDataOut,
  input wire logic emifWrStrobe,
  input wire logic emifRdStrobe,
  input wire logic emifAle,
  output logic canTxPushPull,
  output logic comparator2RouteEn,
  output logic adc2ConvStartRouteEn,
  output logic timer3ExtRouteEn,
  output logic timer3InputRouteEn,
  output logic globalPullupDisable
);
  import pio_pkg::*;

  // Register state and next values
  pio_byte_type latch_r [8];
  pio_byte_type latch_nxt [8];
  pio_byte_type mode_r [8];
  pio_byte_type mode_nxt [8];
  pio_byte_type inMode1_r, inMode1_nxt;
  pio_byte_type route2_r, route2_nxt;
  pio_byte_type route3_r, route3_nxt;
  pio_byte_type rdata_r, rdata_nxt;
  // Synchroniser stages and pin drive
  logic [63:0] pinMeta_r, pinSync_r;
  logic [63:0] pinMeta_nxt, pinSync_nxt;
  logic [63:0] drvLevel, drvEn;

  ////////////////////////////////////////////////////////////////////////
  // Address helpers

  // Ports four to seven sit on the high page
  function automatic logic isHigh(input logic [2:0] n);
    isHigh = (n >= 3'd4);
  endfunction

  // Data register address of each port
  function automatic logic [7:0] portAddr(input logic [2:0] n);
    case (n)
      3'd0: portAddr = `PIO_ADDR_PORT0;
      3'd1: portAddr = `PIO_ADDR_PORT1;
      3'd2: portAddr = `PIO_ADDR_PORT2;
      3'd3: portAddr = `PIO_ADDR_PORT3;
      3'd4: portAddr = `PIO_ADDR_PORT4;
      3'd5: portAddr = `PIO_ADDR_PORT5;
      3'd6: portAddr = `PIO_ADDR_PORT6;
      default: portAddr = `PIO_ADDR_PORT7;
    endcase
  endfunction

  // Output mode register address of each port
  function automatic logic [7:0] modeAddr(input logic [2:0] n);
    case (n)
      3'd0: modeAddr = `PIO_ADDR_MODE0;
      3'd1: modeAddr = `PIO_ADDR_MODE1;
      3'd2: modeAddr = `PIO_ADDR_MODE2;
      3'd3: modeAddr = `PIO_ADDR_MODE3;
      3'd4: modeAddr = `PIO_ADDR_MODE4;
      3'd5: modeAddr = `PIO_ADDR_MODE5;
      3'd6: modeAddr = `PIO_ADDR_MODE6;
      default: modeAddr = `PIO_ADDR_MODE7;
    endcase
  endfunction

  // Page gate for the high ports
  function automatic logic pageOk(input logic [2:0] n, input logic [7:0] pg);
    pageOk = !isHigh(n) || (pg == `PIO_PAGE_HIGH);
  endfunction

  // Bits that have a pin behind them
  function automatic logic [7:0] implMask(input logic [2:0] n);
    implMask = (n == 3'd4) ? `PIO_PORT4_MASK : 8'hFF;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, two stages

  // Only the second stage feeds any logic
  always_comb begin
    pinMeta_nxt = pinIn;
    pinSync_nxt = pinMeta_r;
  end

  // Stage registers, cleared in reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pinMeta_r <= 64'h0000_0000_0000_0000;
      pinSync_r <= 64'h0000_0000_0000_0000;
    end else begin
      pinMeta_r <= pinMeta_nxt;
      pinSync_r <= pinSync_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register next values

  always_comb begin
    logic [2:0] pn;
    logic [7:0] live;
    pn = 3'd0;
    live = 8'h00;
    inMode1_nxt = inMode1_r;
    route2_nxt = route2_r;
    route3_nxt = route3_r;
    rdata_nxt = rdata_r;
    for (int i = 0; i < 8; i++) begin
      latch_nxt[i] = latch_r[i];
      mode_nxt[i] = mode_r[i];
    end
    // Byte, bit and mode writes; a same-cycle bit write wins its bit
    for (int i = 0; i < 8; i++) begin
      pn = 3'(i);
      // Unbonded ports keep full registers
      if (sfrWrite && sfrAddr == portAddr(pn) && pageOk(pn, registerPageSelect)) begin
        latch_nxt[i] = sfrWdata;
      end
      if (sfrBitWrite && sfrAddr == portAddr(pn) && pageOk(pn, registerPageSelect)) begin
        latch_nxt[i][sfrBitSel] = sfrBitVal;
      end
      if (sfrWrite && sfrAddr == modeAddr(pn) && pageOk(pn, registerPageSelect)) begin
        mode_nxt[i] = sfrWdata;
      end
    end
    if (sfrWrite && sfrAddr == `PIO_ADDR_IMODE1) begin
      inMode1_nxt = sfrWdata;
    end
    if (sfrWrite && sfrAddr == `PIO_ADDR_ROUTE2) begin
      route2_nxt = sfrWdata & `PIO_ROUTE2_RW_MASK;
    end
    if (sfrWrite && sfrAddr == `PIO_ADDR_ROUTE3) begin
      route3_nxt = sfrWdata & `PIO_ROUTE3_RW_MASK;
    end
    // Read data, zero for unmapped
    if (sfrRead) begin
      rdata_nxt = 8'h00;
      for (int i = 0; i < 8; i++) begin
        pn = 3'(i);
        live = pinSync_r[i*8 +: 8];
        if (i == 1) begin
          live = live & inMode1_r;
        end
        if (sfrAddr == portAddr(pn) && pageOk(pn, registerPageSelect)) begin
          // Latch on read-modify-write, pins otherwise
          rdata_nxt = (sfrRmwRead ? latch_r[i] : live) & implMask(pn);
        end
        if (sfrAddr == modeAddr(pn) && pageOk(pn, registerPageSelect)) begin
          rdata_nxt = mode_r[i] & implMask(pn);
        end
      end
      if (sfrAddr == `PIO_ADDR_IMODE1) begin
        rdata_nxt = inMode1_r;
      end
      if (sfrAddr == `PIO_ADDR_ROUTE2) begin
        rdata_nxt = route2_r;
      end
      if (sfrAddr == `PIO_ADDR_ROUTE3) begin
        rdata_nxt = route3_r;
      end
    end
  end

  // Register state; reset raises latches and opens all drains
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        latch_r[i] <= `PIO_LATCH_RST;
        mode_r[i] <= `PIO_MODE_RST;
      end
      inMode1_r <= `PIO_IMODE_RST;
      route2_r <= `PIO_ROUTE_RST;
      route3_r <= `PIO_ROUTE_RST;
      rdata_r <= 8'h00;
    end else begin
      for (int i = 0; i < 8; i++) begin
        latch_r[i] <= latch_nxt[i];
        mode_r[i] <= mode_nxt[i];
      end
      inMode1_r <= inMode1_nxt;
      route2_r <= route2_nxt;
      route3_r <= route3_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drive: latch and mode, overridden by the memory interface

  always_comb begin
    logic muxed;
    logic take;
    muxed = (emifMode == PIO_EXTERNAL_MEMORY_INTERFACE_MUX);
    take = emifActive && (emifMode != PIO_EXTERNAL_MEMORY_INTERFACE_OFF);
    for (int i = 0; i < 8; i++) begin
      for (int b = 0; b < 8; b++) begin
        drvLevel[i*8+b] = latch_r[i][b];
        // One drives high only in push-pull
        drvEn[i*8+b] = mode_r[i][b] | ~latch_r[i][b];
      end
    end
    if (take) begin
      drvLevel[32+`PIO_WR_BIT] = emifWrStrobe;
      drvLevel[32+`PIO_RD_BIT] = emifRdStrobe;
      drvLevel[32+`PIO_ALE_BIT] = emifAle;
      if (muxed) begin
        drvLevel[55:48] = emifAddr[15:8];
        drvLevel[63:56] = emifAle ? emifAddr[7:0] : emifDataOut;
      end else begin
        drvLevel[47:40] = emifAddr[15:8];
        drvLevel[55:48] = emifAddr[7:0];
        drvLevel[63:56] = emifDataOut;
      end
      for (int b = 0; b < 8; b++) begin
        // Modes unchanged, recomputed on new levels
        drvEn[32+b] = mode_r[4][b] | ~drvLevel[32+b];
        drvEn[40+b] = mode_r[5][b] | ~drvLevel[40+b];
        drvEn[48+b] = mode_r[6][b] | ~drvLevel[48+b];
        drvEn[56+b] = mode_r[7][b] | ~drvLevel[56+b];
      end
      // Multiplexed address phase still drives the shared bus
      if (emifExtRead && !(muxed && emifAle)) begin
        drvEn[63:56] = 8'h00;
      end
    end
    drvEn[36:32] = 5'h00;
    drvLevel[36:32] = 5'h00;
  end

  // Outputs; pull-up off when disabled or driving low
  assign pinOut = drvLevel;
  assign pinOe = drvEn;
  assign globalPullupDisable = route2_r[`PIO_PUD_BIT];
  // Per-pin pull-up; analog port-one pins lose theirs
  always_comb begin
    for (int k = 0; k < 64; k++) begin
      pullupEn[k] = !globalPullupDisable && !(drvEn[k] && !drvLevel[k]);
    end
    pullupEn[15:8] = pullupEn[15:8] & inMode1_r;
    pullupEn[36:32] = 5'h00;
  end
  // Registered read data
  assign sfrRdata = rdata_r;
  // Routing enables straight from register three
  assign canTxPushPull = route3_r[`PIO_CANPP_BIT];
  assign comparator2RouteEn = route3_r[`PIO_CMP2_BIT];
  assign adc2ConvStartRouteEn = route3_r[`PIO_ADC2_BIT];
  assign timer3ExtRouteEn = route3_r[`PIO_TIMER3_EXT_INPUT_BIT];
  assign timer3InputRouteEn = route3_r[`PIO_T3IN_BIT];

endmodule
`default_nettype wire

//--- logic/pio_defines.svh
/*
 Register addresses, page codes, reset values and field positions of the port block.
 Assumes inclusion by bare name from logic/.
*/
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH
`define PIO_ADDR_PORT0 8'h80
`define PIO_ADDR_PORT1 8'h90
`define PIO_ADDR_PORT2 8'hA0
`define PIO_ADDR_PORT3 8'hB0
`define PIO_ADDR_PORT4 8'hC8
`define PIO_ADDR_PORT5 8'hD8
`define PIO_ADDR_PORT6 8'hE8
`define PIO_ADDR_PORT7 8'hF8
`define PIO_ADDR_MODE0 8'hA4
`define PIO_ADDR_MODE1 8'hA5
`define PIO_ADDR_MODE2 8'hA6
`define PIO_ADDR_MODE3 8'hA7
`define PIO_ADDR_MODE4 8'h9C
`define PIO_ADDR_MODE5 8'h9D
`define PIO_ADDR_MODE6 8'h9E
`define PIO_ADDR_MODE7 8'h9F
`define PIO_ADDR_IMODE1 8'hAD
`define PIO_ADDR_ROUTE2 8'hE3
`define PIO_ADDR_ROUTE3 8'hE4
`define PIO_PAGE_HIGH 8'h0F
`define PIO_LATCH_RST 8'hFF
`define PIO_MODE_RST 8'h00
`define PIO_IMODE_RST 8'hFF
`define PIO_ROUTE_RST 8'h00
`define PIO_PORT4_MASK 8'hE0
`define PIO_ROUTE3_RW_MASK 8'h8F
`define PIO_ROUTE2_RW_MASK 8'hDC
`define PIO_PUD_BIT 7
`define PIO_CANPP_BIT 7
`define PIO_WR_BIT 7
`define PIO_RD_BIT 6
`define PIO_ALE_BIT 5
`define PIO_CMP2_BIT 3
`define PIO_ADC2_BIT 2
`define PIO_TIMER3_EXT_INPUT_BIT 1
`define PIO_T3IN_BIT 0
`endif

//--- logic/pio_pkg.sv
/*
 Types shared by the port block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pio_pkg;
  typedef logic [7:0] pio_byte_type;
  typedef logic [2:0] pio_index_type;
  typedef enum logic [1:0] {
    PIO_EXTERNAL_MEMORY_INTERFACE_OFF = 2'b00,
    PIO_EXTERNAL_MEMORY_INTERFACE_MUX = 2'b01,
    PIO_EXTERNAL_MEMORY_INTERFACE_NONMUX = 2'b10
  } pio_external_memory_interface_mode_type;
endpackage

//--- tb/pio_port_ctrl_props.sv
/* Concurrent checks on the port block's pins, routing bits and reads.
 Assumes a bind into pio_port_ctrl on one clock. */
`timescale 1ns/1ps
`default_nettype none
`include "pio_defines.svh"
module pio_port_ctrl_props
  import pio_pkg::*;
(
  input wire logic clock, sys_rst, sfrWrite, sfrRead, emifActive, emifExtRead,
  input wire logic emifWrStrobe, emifRdStrobe, emifAle, canTxPushPull,
  input wire logic comparator2RouteEn, adc2ConvStartRouteEn, timer3ExtRouteEn,
  input wire logic timer3InputRouteEn, globalPullupDisable,
  input wire logic [7:0] sfrAddr, sfrWdata,
  input wire pio_pkg::pio_byte_type registerPageSelect, sfrRdata,
  input wire logic [63:0] pinOut, pinOe, pullupEn,
  input wire pio_pkg::pio_external_memory_interface_mode_type emifMode,
  input wire logic [15:0] emifAddr
);
  logic [7:0] wdPrev_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Write data one cycle back
  always_ff @(posedge clock) wdPrev_r <= sfrWdata;
  // Steps of register writes and memory moves
  sequence s_rt3_wr; sfrWrite && sfrAddr == `PIO_ADDR_ROUTE3; endsequence
  sequence s_rt2_wr; sfrWrite && sfrAddr == `PIO_ADDR_ROUTE2; endsequence
  sequence s_nonmux; emifActive && emifMode == PIO_EXTERNAL_MEMORY_INTERFACE_NONMUX; endsequence
  sequence s_mux; emifActive && emifMode == PIO_EXTERNAL_MEMORY_INTERFACE_MUX; endsequence
  a_reset_open_drain: assert property ($fell(sys_rst) && !emifActive |-> pinOe == 64'h0)
    else $error("pins driven after reset");
  a_route3_bits: assert property (s_rt3_wr |=> {canTxPushPull, comparator2RouteEn,
    adc2ConvStartRouteEn, timer3ExtRouteEn, timer3InputRouteEn} == {wdPrev_r[7], wdPrev_r[3:0]})
    else $error("routing bits differ from write");
  a_pud_write: assert property (s_rt2_wr |=> globalPullupDisable == wdPrev_r[7])
    else $error("pull-up disable bit not written");
  a_pud_all_off: assert property (globalPullupDisable |-> pullupEn == 64'h0)
    else $error("pull-up on while disabled");
  a_low_no_pull: assert property ((pinOe & ~pinOut & pullupEn) == 64'h0)
    else $error("pull-up on a pin driven low");
  a_port4_empty: assert property ((pinOe[36:32] | pullupEn[36:32]) == 5'h00)
    else $error("absent port four pin active");
  a_page_refused: assert property (sfrRead && sfrAddr == `PIO_ADDR_PORT5 &&
    registerPageSelect != `PIO_PAGE_HIGH |=> sfrRdata == 8'h00)
    else $error("high port read off its page");
  a_external_memory_interface_strobes: assert property (emifActive && emifMode != PIO_EXTERNAL_MEMORY_INTERFACE_OFF |->
    pinOut[39:37] == {emifWrStrobe, emifRdStrobe, emifAle})
    else $error("strobes not on port four");
  a_nonmux_addr: assert property (s_nonmux |-> pinOut[55:40] == {emifAddr[7:0], emifAddr[15:8]})
    else $error("address bytes misplaced");
  a_mux_high: assert property (s_mux |-> pinOut[55:48] == emifAddr[15:8])
    else $error("high address not on port six");
  a_read_release: assert property (s_nonmux ##0 emifExtRead |-> pinOe[63:56] == 8'h00)
    else $error("data bus driven in read move");
endmodule
bind pio_port_ctrl pio_port_ctrl_props u_props (.*);
`default_nettype wire

//--- tb/pio_pin_model.sv
/* Circuitry outside the port pins: outside drivers, pull-ups, noise.
 Assumes the pin vectors of pio_port_ctrl. */
`timescale 1ns/1ps
`default_nettype none
module pio_pin_model (
  input wire logic clock,
  input wire logic [63:0] pinOut, pinOe, pullupEn, extDrv, extEn,
  output logic [63:0] pinIn
);
  logic noise_r = 1'b0;
  // Undriven wire with no pull-up wanders
  always_ff @(posedge clock) noise_r <= ~noise_r;
  // Device drive, else outside drive, else pull-up or noise
  assign pinIn = (pinOe & pinOut) | (~pinOe & extEn & extDrv) |
    (~pinOe & ~extEn & (pullupEn | {64{noise_r}}));
endmodule
`default_nettype wire

//--- tb/port_io_latch_and_mode_control_test.sv
/* Self-checking bench of the port block.
 Assumes pio_port_ctrl, its bound checker and pio_pin_model. */
`timescale 1ns/1ps
`default_nettype none
module port_io_latch_and_mode_control_test;
  import pio_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, sfrWrite = '0, sfrBitWrite = '0, sfrBitVal = '0;
  logic sfrRead = '0, sfrRmwRead = '0, emifActive = '0, emifExtRead = '0, emifWrStrobe = '0;
  logic emifRdStrobe = '0, emifAle = '0, canTxPushPull, comparator2RouteEn;
  logic adc2ConvStartRouteEn, timer3ExtRouteEn, timer3InputRouteEn, globalPullupDisable;
  logic [7:0] sfrAddr = '0, sfrWdata = '0, emifDataOut = '0;
  logic [15:0] emifAddr = '0;
  logic [63:0] pinIn, pinOut, pinOe, pullupEn, extDrv = '0, extEn = '0;
  pio_byte_type registerPageSelect = '0, sfrRdata;
  pio_index_type sfrBitSel = '0;
  pio_external_memory_interface_mode_type emifMode = PIO_EXTERNAL_MEMORY_INTERFACE_OFF;
  int fails = 0, checks = 0, cycles = 0;
  pio_port_ctrl DUT (.*);
  pio_pin_model pins (.*);
  always #5 clock = ~clock;
  // Cycle ceiling against a hang
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] e);
    checks++;
    if (seen !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWdata = d;
    sfrWrite = 1'b1;
    wt(1);
    sfrWrite = 1'b0;
    wt(1);
  endtask
  task automatic bw(input logic [2:0] b, input logic v);
    sfrAddr = 8'h90;
    sfrBitSel = b;
    sfrBitVal = v;
    sfrBitWrite = 1'b1;
    wt(1);
    sfrBitWrite = 1'b0;
    wt(1);
  endtask
  task automatic rc(input logic [7:0] a, input logic m, input logic [7:0] e, input string n);
    sfrAddr = a;
    sfrRead = 1'b1;
    sfrRmwRead = m;
    wt(1);
    sfrRead = 1'b0;
    sfrRmwRead = 1'b0;
    chk(n, sfrRdata, e);
    wt(1);
  endtask
  // Reset state of pins and registers
  task automatic t_reset;
    chk("oe", pinOe, 64'h0);
    chk("pull", pullupEn, 64'hFFFF_FFE0_FFFF_FFFF);
    rc(8'h90, 1'b1, 8'hFF, "latch1");
    rc(8'hE4, 1'b0, 8'h00, "rt3rst");
  endtask
  // Drive modes, pin versus latch reads, analog pin, bit writes
  task automatic t_drive;
    wr(8'hA5, 8'h0F);
    wr(8'h90, 8'h35);
    extEn = 64'h2000;
    wt(3);
    chk("oe1", pinOe[15:8], 8'hCF);
    chk("out1", pinOut[15:8] & 8'hCF, 8'h05);
    chk("pu1", pullupEn[15:8], 8'h35);
    rc(8'h90, 1'b0, 8'h15, "pin1");
    rc(8'h90, 1'b1, 8'h35, "rmw1");
    wr(8'hAD, 8'hEF);
    rc(8'h90, 1'b0, 8'h05, "ana");
    chk("puana", {pullupEn[12], pinOe[15:8]}, 9'h0CF);
    bw(3'd1, 1'b1);
    bw(3'd0, 1'b0);
    rc(8'h90, 1'b1, 8'h36, "bitw");
    wr(8'hAD, 8'hFF);
    extEn = '0;
  endtask
  // Page gate, port four width, unbonded port, unmapped place
  task automatic t_page;
    wr(8'hD8, 8'h00);
    rc(8'hD8, 1'b1, 8'h00, "offpg");
    registerPageSelect = 8'h0F;
    rc(8'hD8, 1'b1, 8'hFF, "kept");
    wr(8'hD8, 8'h00);
    rc(8'hD8, 1'b1, 8'h00, "p5");
    wr(8'hC8, 8'h1F);
    rc(8'hC8, 1'b1, 8'h00, "p4");
    registerPageSelect = 8'h00;
    wr(8'hB0, 8'h00);
    rc(8'hB0, 1'b1, 8'h00, "p3");
    rc(8'h00, 1'b0, 8'h00, "unmap");
  endtask
  // Global pull-up disable and every routing bit
  task automatic t_route;
    int i;
    wr(8'hE3, 8'hFF);
    chk("pud", globalPullupDisable, 1'b1);
    chk("puoff", pullupEn, 64'h0);
    rc(8'hE3, 1'b0, 8'hDC, "rt2");
    wr(8'hE3, 8'h00);
    for (i = 0; i < 5; i++) begin
      wr(8'hE4, i == 4 ? 8'h80 : 8'h01 << i);
      chk("rt3", {canTxPushPull, comparator2RouteEn, adc2ConvStartRouteEn, timer3ExtRouteEn,
        timer3InputRouteEn}, 5'h01 << i);
    end
    wr(8'hE4, 8'hFF);
    rc(8'hE4, 1'b0, 8'h8F, "rt3rd");
  endtask
  // Memory interface takeover in both modes
  task automatic t_external_memory_interface;
    emifAddr = 16'h1234;
    emifDataOut = 8'hA5;
    {emifWrStrobe, emifRdStrobe, emifAle} = 3'b101;
    emifMode = PIO_EXTERNAL_MEMORY_INTERFACE_NONMUX;
    emifActive = 1'b1;
    wt(1);
    chk("nm", pinOut[63:37], {8'hA5, 8'h34, 8'h12, 3'b101});
    emifExtRead = 1'b1;
    wt(1);
    chk("rdoff", pinOe[63:56], 8'h00);
    emifExtRead = 1'b0;
    emifMode = PIO_EXTERNAL_MEMORY_INTERFACE_MUX;
    wt(1);
    chk("mx", pinOut[63:48], 16'h3412);
    emifAle = 1'b0;
    wt(1);
    chk("mxd", pinOut[63:56], 8'hA5);
    emifExtRead = 1'b1;
    wt(1);
    chk("mxrd", pinOe[63:56], 8'h00);
    emifExtRead = 1'b0;
    emifActive = 1'b0;
    wt(1);
    chk("mode", pinOe[47:40], 8'hFF);
  endtask
  initial begin
    wt(4);
    sys_rst = 1'b0;
    t_reset;
    t_drive;
    t_page;
    t_route;
    t_external_memory_interface;
    print_verdict;
  end
endmodule
`default_nettype wire
